// ===== common/eti_pkg.sv
package eti_pkg;

    localparam int ETI_NUM_CH = 32;
    localparam int ETI_NUM_PROG = 20;
    localparam int ETI_NUM_FIXED = 12;
    localparam int ETI_NUM_GRP = 6;
    localparam int ETI_NUM_EVT = 16;
    localparam int ETI_NUM_TASK = 16;
    localparam int ETI_NUM_SHORT = 4;
    localparam int ETI_AW = 12;

    // Register offsets, byte addresses
    localparam logic [11:0] ETI_OFF_GRP_TASK = 12'h000;
    localparam logic [11:0] ETI_GRP_TASK_STRIDE = 12'h008;
    localparam logic [11:0] ETI_OFF_CHAN_EN = 12'h500;
    localparam logic [11:0] ETI_OFF_CHAN_SET = 12'h504;
    localparam logic [11:0] ETI_OFF_CHAN_CLR = 12'h508;
    localparam logic [11:0] ETI_OFF_CH = 12'h510;
    localparam logic [11:0] ETI_CH_STRIDE = 12'h008;
    localparam logic [11:0] ETI_OFF_TASK_IN_CH = 12'h004;
    localparam logic [11:0] ETI_OFF_GRP = 12'h800;
    localparam logic [11:0] ETI_OFF_FORK = 12'h910;
    localparam logic [11:0] ETI_WORD = 12'h004;

    // System addresses that endpoints are compared against
    localparam logic [31:0] ETI_BLOCK_BASE = 32'h4001_f000;
    localparam logic [31:0] ETI_EVT_BASE = 32'h4000_8100;
    localparam logic [31:0] ETI_TASK_BASE = 32'h4000_8000;

    // Reset values
    localparam logic [31:0] ETI_EP_RESET = 32'h0000_0000;
    localparam logic [31:0] ETI_CHAN_EN_RESET = 32'h0000_0000;
    localparam logic [31:0] ETI_GRP_RESET = 32'h0000_0000;

    // Event line indices
    localparam int ETI_EV_TMR_CMP0 = 0;
    localparam int ETI_EV_TMR_CMP1 = 1;
    localparam int ETI_EV_RAD_BCMATCH = 2;
    localparam int ETI_EV_RAD_READY = 3;
    localparam int ETI_EV_RAD_ADDR = 4;
    localparam int ETI_EV_RAD_END = 5;
    localparam int ETI_EV_RTC_CMP0 = 6;

    // Task line indices
    localparam int ETI_TK_RAD_TXEN = 0;
    localparam int ETI_TK_RAD_RXEN = 1;
    localparam int ETI_TK_RAD_DISABLE = 2;
    localparam int ETI_TK_ADDR_RES_START = 3;
    localparam int ETI_TK_KEYGEN = 4;
    localparam int ETI_TK_CRYPT = 5;
    localparam int ETI_TK_TMR_CAP1 = 6;
    localparam int ETI_TK_TMR_CAP2 = 7;
    localparam int ETI_TK_TMR_CLEAR = 8;
    localparam int ETI_TK_TMR_START = 9;

    // Fixed routing of channels 20..31, entry i is channel 20+i
    localparam int ETI_HW_EVT [ETI_NUM_FIXED] = '{
        ETI_EV_TMR_CMP0, ETI_EV_TMR_CMP0, ETI_EV_TMR_CMP1, ETI_EV_RAD_BCMATCH,
        ETI_EV_RAD_READY, ETI_EV_RAD_ADDR, ETI_EV_RAD_ADDR, ETI_EV_RAD_END,
        ETI_EV_RTC_CMP0, ETI_EV_RTC_CMP0, ETI_EV_RTC_CMP0, ETI_EV_RTC_CMP0};
    localparam int ETI_HW_TASK [ETI_NUM_FIXED] = '{
        ETI_TK_RAD_TXEN, ETI_TK_RAD_RXEN, ETI_TK_RAD_DISABLE, ETI_TK_ADDR_RES_START,
        ETI_TK_KEYGEN, ETI_TK_CRYPT, ETI_TK_TMR_CAP1, ETI_TK_TMR_CAP2,
        ETI_TK_RAD_TXEN, ETI_TK_RAD_RXEN, ETI_TK_TMR_CLEAR, ETI_TK_TMR_START};

endpackage : eti_pkg

// ===== hw/eti_ep_decode.sv
`timescale 1ns/10ps
// Compares one endpoint address against a run of word-spaced register addresses
module eti_ep_decode #(
    parameter logic [31:0] BASE = 32'h0000_0000,
    parameter int COUNT = 1
) (
    input wire logic [31:0] addr_i,
    output wire logic [COUNT-1:0] hit_o
);

    genvar k;
    // Exact match only, so address zero or a stray value selects nothing
    generate
        for (k = 0; k < COUNT; k++) begin : g_hit
            assign hit_o[k] = (addr_i == (BASE + 32'(4 * k)));
        end
    endgenerate

endmodule : eti_ep_decode

// ===== hw/eti_interconnect.sv
`timescale 1ns/10ps
module eti_interconnect
    import eti_pkg::*;
#(
    parameter int NUM_GRP = ETI_NUM_GRP,
    parameter int NUM_EVT = ETI_NUM_EVT,
    parameter int NUM_TASK = ETI_NUM_TASK,
    parameter int NUM_SHORT = ETI_NUM_SHORT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [ETI_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [NUM_EVT-1:0] event_i,
    output logic [NUM_TASK-1:0] task_o,
    input wire logic [NUM_SHORT-1:0] short_evt_i,
    output logic [NUM_SHORT-1:0] short_task_o
);

    localparam int NGT = 2 * NUM_GRP;

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [31:0] evt_ep_q [ETI_NUM_PROG];
    logic [31:0] evt_ep_d [ETI_NUM_PROG];
    logic [31:0] task_ep_q [ETI_NUM_PROG];
    logic [31:0] task_ep_d [ETI_NUM_PROG];
    logic [31:0] fork_ep_q [ETI_NUM_CH];
    logic [31:0] fork_ep_d [ETI_NUM_CH];
    logic [31:0] grp_q [NUM_GRP];
    logic [31:0] grp_d [NUM_GRP];
    logic [31:0] chan_en_q;
    logic [31:0] chan_en_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [NUM_EVT-1:0] evt_q;
    logic [NUM_TASK-1:0] task_q;
    logic [NUM_TASK-1:0] task_d;
    logic [NUM_SHORT-1:0] short_q;

    // Per-channel selections, one-hot or zero
    logic [NUM_EVT-1:0] evt_sel [ETI_NUM_CH];
    logic [NUM_TASK-1:0] pri_tsel [ETI_NUM_CH];
    logic [NUM_TASK-1:0] fork_tsel [ETI_NUM_CH];
    logic [NGT-1:0] pri_gsel [ETI_NUM_CH];
    logic [NGT-1:0] fork_gsel [ETI_NUM_CH];
    logic [ETI_NUM_CH-1:0] fired;

    // Bus side strobes and group task requests
    logic chan_en_wr;
    logic [31:0] set_sw;
    logic [31:0] clr_sw;
    logic [31:0] set_all;
    logic [31:0] clr_all;
    logic [NUM_GRP-1:0] grp_en_sw;
    logic [NUM_GRP-1:0] grp_dis_sw;
    logic [NUM_GRP-1:0] grp_en;
    logic [NUM_GRP-1:0] grp_dis;
    logic [NGT-1:0] grp_ch;

    assign rdata_o = rdata_q;
    assign task_o = task_q;
    assign short_task_o = short_q;

    ////////////////////////////////////////////////////////////////////////////
    // Endpoint decode per channel
    genvar c;
    generate
        for (c = 0; c < ETI_NUM_CH; c++) begin : g_ch
            if (c < ETI_NUM_PROG) begin : g_prog
                // Programmable: addresses decoded against event, task and own group tasks
                eti_ep_decode #(.BASE(ETI_EVT_BASE), .COUNT(NUM_EVT)) u_evt (
                    .addr_i(evt_ep_q[c]),
                    .hit_o(evt_sel[c])
                );
                eti_ep_decode #(.BASE(ETI_TASK_BASE), .COUNT(NUM_TASK)) u_task (
                    .addr_i(task_ep_q[c]),
                    .hit_o(pri_tsel[c])
                );
                eti_ep_decode #(.BASE(ETI_BLOCK_BASE), .COUNT(NGT)) u_grp (
                    .addr_i(task_ep_q[c]),
                    .hit_o(pri_gsel[c])
                );
            end else begin : g_fixed
                // Fixed routing, no register behind it so software cannot alter it
                assign evt_sel[c] = {{(NUM_EVT-1){1'b0}}, 1'b1}
                    << ETI_HW_EVT[c-ETI_NUM_PROG];
                assign pri_tsel[c] = {{(NUM_TASK-1){1'b0}}, 1'b1}
                    << ETI_HW_TASK[c-ETI_NUM_PROG];
                assign pri_gsel[c] = '0;
            end
            // Secondary task entry n belongs to channel n, fixed channels included
            eti_ep_decode #(.BASE(ETI_TASK_BASE), .COUNT(NUM_TASK)) u_fork_task (
                .addr_i(fork_ep_q[c]),
                .hit_o(fork_tsel[c])
            );
            eti_ep_decode #(.BASE(ETI_BLOCK_BASE), .COUNT(NGT)) u_fork_grp (
                .addr_i(fork_ep_q[c]),
                .hit_o(fork_gsel[c])
            );
            // A disabled channel drops its event
            assign fired[c] = chan_en_q[c] & (|(evt_sel[c] & evt_q));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register bus: decode, write next values, read data for the next cycle
    always_comb begin
        chan_en_wr = 1'b0;
        set_sw = '0;
        clr_sw = '0;
        grp_en_sw = '0;
        grp_dis_sw = '0;
        rdata_d = '0;
        evt_ep_d = evt_ep_q;
        task_ep_d = task_ep_q;
        fork_ep_d = fork_ep_q;
        grp_d = grp_q;
        if (addr_i == ETI_OFF_CHAN_EN || addr_i == ETI_OFF_CHAN_SET
            || addr_i == ETI_OFF_CHAN_CLR) begin
            chan_en_wr = wr_i && (addr_i == ETI_OFF_CHAN_EN);
            if (wr_i && addr_i == ETI_OFF_CHAN_SET) begin
                set_sw = wdata_i;
            end
            if (wr_i && addr_i == ETI_OFF_CHAN_CLR) begin
                clr_sw = wdata_i;
            end
            if (rd_i) begin
                rdata_d = chan_en_q;
            end
        end
        for (int g = 0; g < NUM_GRP; g++) begin
            // Task words read as zero; a write of any value triggers the task
            if (wr_i && addr_i == ETI_OFF_GRP_TASK + 12'(g) * ETI_GRP_TASK_STRIDE) begin
                grp_en_sw[g] = 1'b1;
            end
            if (wr_i && addr_i == ETI_OFF_GRP_TASK + 12'(g) * ETI_GRP_TASK_STRIDE
                + ETI_WORD) begin
                grp_dis_sw[g] = 1'b1;
            end
            if (addr_i == ETI_OFF_GRP + 12'(g) * ETI_WORD) begin
                if (wr_i) begin
                    grp_d[g] = wdata_i;
                end
                if (rd_i) begin
                    rdata_d = grp_q[g];
                end
            end
        end
        for (int i = 0; i < ETI_NUM_PROG; i++) begin
            if (addr_i == ETI_OFF_CH + 12'(i) * ETI_CH_STRIDE) begin
                if (wr_i) begin
                    evt_ep_d[i] = wdata_i;
                end
                if (rd_i) begin
                    rdata_d = evt_ep_q[i];
                end
            end
            if (addr_i == ETI_OFF_CH + 12'(i) * ETI_CH_STRIDE + ETI_OFF_TASK_IN_CH) begin
                if (wr_i) begin
                    task_ep_d[i] = wdata_i;
                end
                if (rd_i) begin
                    rdata_d = task_ep_q[i];
                end
            end
        end
        for (int i = 0; i < ETI_NUM_CH; i++) begin
            if (addr_i == ETI_OFF_FORK + 12'(i) * ETI_WORD) begin
                if (wr_i) begin
                    fork_ep_d[i] = wdata_i;
                end
                if (rd_i) begin
                    rdata_d = fork_ep_q[i];
                end
            end
        end
    end

    // Configuration registers; endpoints reset to zero, which matches nothing
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
            for (int i = 0; i < ETI_NUM_PROG; i++) begin
                evt_ep_q[i] <= ETI_EP_RESET;
                task_ep_q[i] <= ETI_EP_RESET;
            end
            for (int i = 0; i < ETI_NUM_CH; i++) begin
                fork_ep_q[i] <= ETI_EP_RESET;
            end
            for (int g = 0; g < NUM_GRP; g++) begin
                grp_q[g] <= ETI_GRP_RESET;
            end
        end else begin
            rdata_q <= rdata_d;
            evt_ep_q <= evt_ep_d;
            task_ep_q <= task_ep_d;
            fork_ep_q <= fork_ep_d;
            grp_q <= grp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel enables: group tasks from software or from channels, set beats clear
    always_comb begin
        grp_ch = '0;
        for (int i = 0; i < ETI_NUM_CH; i++) begin
            if (fired[i]) begin
                grp_ch = grp_ch | pri_gsel[i] | fork_gsel[i];
            end
        end
        set_all = set_sw;
        clr_all = clr_sw;
        for (int g = 0; g < NUM_GRP; g++) begin
            grp_en[g] = grp_en_sw[g] | grp_ch[2*g];
            grp_dis[g] = grp_dis_sw[g] | grp_ch[2*g+1];
            if (grp_en[g]) begin
                set_all = set_all | grp_q[g];
            end
            if (grp_dis[g]) begin
                clr_all = clr_all | grp_q[g];
            end
        end
        // Enable applied last so it overrides any simultaneous disable
        chan_en_d = ((chan_en_wr ? wdata_i : chan_en_q) & ~clr_all) | set_all;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            chan_en_q <= ETI_CHAN_EN_RESET;
        end else begin
            chan_en_q <= chan_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event to task path; one register stage on events, one on tasks
    always_comb begin
        task_d = '0;
        for (int i = 0; i < ETI_NUM_CH; i++) begin
            if (fired[i]) begin
                task_d = task_d | pri_tsel[i] | fork_tsel[i];
            end
        end
    end

    // Shortcuts skip the event stage, so they arrive one cycle ahead of channels
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            evt_q <= '0;
            task_q <= '0;
            short_q <= '0;
        end else begin
            evt_q <= event_i;
            task_q <= task_d;
            short_q <= short_evt_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_fixed_route;
        event_i[ETI_EV_TMR_CMP0] ##1 chan_en_q[20] |=> task_o[ETI_TK_RAD_TXEN];
    endproperty
    a_fixed_route: assert property (p_fixed_route) else $error("fixed channel missed task");

    property p_sync_delay;
        task_o != '0 |-> $past(event_i, 2) != '0;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("task without event");

    property p_disabled;
        chan_en_q == '0 |=> task_o == '0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channels fired");

    property p_primary;
        fired[0] |=> (task_o & $past(pri_tsel[0])) == $past(pri_tsel[0]);
    endproperty
    a_primary: assert property (p_primary) else $error("primary task lost");

    property p_fork;
        fired[0] |=> (task_o & $past(fork_tsel[0])) == $past(fork_tsel[0]);
    endproperty
    a_fork: assert property (p_fork) else $error("secondary task lost");

    property p_short;
        short_evt_i[0] |=> short_task_o[0];
    endproperty
    a_short: assert property (p_short) else $error("shortcut delayed");

    property p_en_wins;
        grp_en[0] && grp_dis[0] |=> (chan_en_q & $past(grp_q[0])) == $past(grp_q[0]);
    endproperty
    a_en_wins: assert property (p_en_wins) else $error("group enable lost");

    property p_grp_dis;
        grp_dis[0] && set_all == '0 |=> (chan_en_q & $past(grp_q[0])) == '0;
    endproperty
    a_grp_dis: assert property (p_grp_dis) else $error("group disable failed");

    property p_set;
        wr_i && addr_i == ETI_OFF_CHAN_SET |=> (chan_en_q & $past(wdata_i)) == $past(wdata_i);
    endproperty
    a_set: assert property (p_set) else $error("set register failed");

    property p_clr;
        wr_i && addr_i == ETI_OFF_CHAN_CLR && grp_en == '0
            |=> (chan_en_q & $past(wdata_i)) == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear register failed");

    property p_grp_task;
        fired[2] && pri_gsel[2][0] |=> (chan_en_q & $past(grp_q[0])) == $past(grp_q[0]);
    endproperty
    a_grp_task: assert property (p_grp_task) else $error("channel group task lost");

    property p_rd_ep;
        rd_i && addr_i == ETI_OFF_CH |=> rdata_o == evt_ep_q[0];
    endproperty
    a_rd_ep: assert property (p_rd_ep) else $error("endpoint readback wrong");

    c_fixed: cover property (fired[20]);
    c_both_grp: cover property (grp_en[0] && grp_dis[0]);
    c_fork: cover property (fired[0] && fork_tsel[0] != '0);
    c_chan_grp: cover property (grp_ch != '0);

endmodule : eti_interconnect

// ===== verification/eti_interconnect_tb.sv
`timescale 1ns/10ps
module eti_interconnect_tb
    import eti_pkg::*;
;
    typedef struct {int ch; int ev; int tk; int fk;} eti_row_s;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ETI_AW-1:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [ETI_NUM_EVT-1:0] event_i;
    logic [ETI_NUM_TASK-1:0] task_o;
    logic [ETI_NUM_SHORT-1:0] short_evt_i;
    logic [ETI_NUM_SHORT-1:0] short_task_o;
    int err_count = 0;
    int checks_done = 0;
    logic [15:0] exp_t;
    // Channel, event line, primary task line, secondary task line
    eti_row_s rows [3] = '{'{0, 9, 10, 11}, '{7, 10, 12, 12}, '{19, 15, 15, 3}};

    ////////////////////////////////////////////////////////////////////////////////
    always #25 ref_clk_i = ~ref_clk_i;

    eti_interconnect i_eti_interconnect (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .event_i(event_i),
        .task_o(task_o),
        .short_evt_i(short_evt_i),
        .short_task_o(short_task_o)
    );

    eti_periph_model i_eti_periph_model (
        .ref_clk_i(ref_clk_i),
        .event_o(event_i),
        .short_evt_o(short_evt_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Case equality so an unknown never passes
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Strobe drops at the next edge, so a following call leaves a one-cycle gap
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(what, exp, rdata_o);
        // Read data must drop back to zero once the read cycle is over
        @(negedge ref_clk_i);
        chk({what, " after"}, 32'h0, rdata_o);
    endtask : rd

    // Shortcut shows one cycle after the event, channel tasks two cycles after
    task automatic run(input logic [15:0] ev, input logic [3:0] sh, input logic [15:0] exp);
        i_eti_periph_model.fire(ev, sh);
        @(negedge ref_clk_i);
        chk("short_task_o", 32'(sh), 32'(short_task_o));
        chk("task_o early", 32'h0, 32'(task_o));
        @(negedge ref_clk_i);
        chk("task_o", 32'(exp), 32'(task_o));
        @(negedge ref_clk_i);
        chk("task_o after", 32'h0, 32'(task_o));
        chk("short_task_o after", 32'h0, 32'(short_task_o));
    endtask : run

    task automatic results;
        $display("Checks: %0d errors: %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        results();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd("enable mask", ETI_OFF_CHAN_EN, ETI_CHAN_EN_RESET);
        rd("event endpoint", ETI_OFF_CH, ETI_EP_RESET);
        rd("group mask", ETI_OFF_GRP, ETI_GRP_RESET);
        rd("unmapped", 12'h700, 32'h0);
        run(16'hffff, 4'h0, 16'h0);
        // Table rows: program, enable, fire, disable, fire again
        foreach (rows[i]) begin
            wr(ETI_OFF_CH + 12'(8 * rows[i].ch), ETI_EVT_BASE + 32'(4 * rows[i].ev));
            wr(ETI_OFF_CH + 12'(8 * rows[i].ch) + ETI_OFF_TASK_IN_CH,
                ETI_TASK_BASE + 32'(4 * rows[i].tk));
            wr(ETI_OFF_FORK + 12'(4 * rows[i].ch), ETI_TASK_BASE + 32'(4 * rows[i].fk));
            rd("task endpoint", ETI_OFF_CH + 12'(8 * rows[i].ch) + ETI_OFF_TASK_IN_CH,
                ETI_TASK_BASE + 32'(4 * rows[i].tk));
            wr(ETI_OFF_CHAN_SET, 32'h1 << rows[i].ch);
            exp_t = 16'h0;
            exp_t[rows[i].tk] = 1'b1;
            exp_t[rows[i].fk] = 1'b1;
            run(16'h1 << rows[i].ev, 4'h5, exp_t);
            wr(ETI_OFF_CHAN_CLR, 32'h1 << rows[i].ch);
            rd("enable mask", ETI_OFF_CHAN_EN, 32'h0);
            run(16'h1 << rows[i].ev, 4'ha, 16'h0);
        end
        // Fixed channels: primary endpoints have no address, secondary stays writable
        wr(ETI_OFF_FORK + 12'(4 * 20), ETI_TASK_BASE + 32'(4 * 13));
        wr(ETI_OFF_CH + 12'(8 * 20), ETI_EVT_BASE);
        rd("fixed endpoint", ETI_OFF_CH + 12'(8 * 20), 32'h0);
        wr(ETI_OFF_CHAN_EN, 32'hfff0_0000);
        for (int e = 0; e < 7; e++) begin
            exp_t = (e == 0) ? 16'h2000 : 16'h0;
            for (int j = 0; j < ETI_NUM_FIXED; j++) begin
                if (ETI_HW_EVT[j] == e) begin
                    exp_t[ETI_HW_TASK[j]] = 1'b1;
                end
            end
            run(16'h1 << e, 4'h0, exp_t);
        end
        wr(ETI_OFF_CHAN_EN, 32'h0);
        // Groups: membership first, then tasks by bus and by channel
        wr(ETI_OFF_GRP, 32'h0000_0081);
        wr(ETI_OFF_GRP + ETI_WORD, 32'h0000_0080);
        wr(ETI_OFF_GRP_TASK, 32'h1);
        rd("group enable", ETI_OFF_CHAN_EN, 32'h81);
        rd("group task word", ETI_OFF_GRP_TASK, 32'h0);
        wr(ETI_OFF_CH + 12'h008, ETI_EVT_BASE + 32'(4 * 8));
        wr(ETI_OFF_CH + 12'h00c, ETI_BLOCK_BASE + 32'h0000_000c);
        wr(ETI_OFF_CH + 12'h010, ETI_EVT_BASE + 32'(4 * 8));
        wr(ETI_OFF_CH + 12'h014, ETI_BLOCK_BASE);
        wr(ETI_OFF_CHAN_SET, 32'h6);
        rd("set reads mask", ETI_OFF_CHAN_SET, 32'h87);
        // Group 1 disable and group 0 enable land together on channel 7
        run(16'h0100, 4'h0, 16'h0);
        rd("enable wins", ETI_OFF_CHAN_EN, 32'h87);
        wr(ETI_OFF_GRP_TASK + ETI_WORD, 32'h1);
        rd("group disable", ETI_OFF_CHAN_EN, 32'h6);
        run(16'h0100, 4'h0, 16'h0);
        rd("group by channel", ETI_OFF_CHAN_EN, 32'h87);
        // Same group enabled and disabled in one cycle, beside a group 1 disable
        wr(ETI_OFF_CH + 12'h028, ETI_EVT_BASE + 32'(4 * 8));
        wr(ETI_OFF_CH + 12'h02c, ETI_BLOCK_BASE + 32'h0000_0004);
        wr(ETI_OFF_CHAN_SET, 32'h20);
        run(16'h0100, 4'h0, 16'h0);
        rd("same group enable wins", ETI_OFF_CHAN_EN, 32'ha7);
        // Reset in mid-run must clear endpoints, masks and enables
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd("enable after reset", ETI_OFF_CHAN_EN, ETI_CHAN_EN_RESET);
        rd("endpoint after reset", ETI_OFF_CH + 12'h014, ETI_EP_RESET);
        rd("group after reset", ETI_OFF_GRP, ETI_GRP_RESET);
        run(16'h0100, 4'h3, 16'h0);
        results();
    end
endmodule : eti_interconnect_tb

// ===== verification/eti_periph_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Peripheral side of the interconnect: event and shortcut event sources
module eti_periph_model
    import eti_pkg::*;
#(
    parameter int NUM_EVT = ETI_NUM_EVT,
    parameter int NUM_SHORT = ETI_NUM_SHORT
) (
    input wire logic ref_clk_i,
    output logic [NUM_EVT-1:0] event_o,
    output logic [NUM_SHORT-1:0] short_evt_o
);
    // Event lines idle low between pulses
    initial begin
        event_o = '0;
        short_evt_o = '0;
    end

    // One-cycle event pulse launched just after an edge; endpoints in the
    // interconnect pick lines by register address, so line n sits at ETI_EVT_BASE + 4*n
    task automatic fire(input logic [NUM_EVT-1:0] ev, input logic [NUM_SHORT-1:0] sh);
        @(posedge ref_clk_i);
        event_o <= ev;
        short_evt_o <= sh;
        @(posedge ref_clk_i);
        event_o <= '0;
        short_evt_o <= '0;
    endtask : fire
endmodule : eti_periph_model
